//--- include/pfs_pkg.sv
// package: constants, types and helpers of the pulse programmed fuse trim block
package pfs_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MID_DWELL_US = 15;
  localparam int TOP_DWELL_US = 30;
  localparam int BURN_US = 30;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] MID_DWELL_CYC = CNT_W'(MID_DWELL_US * 1000 / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TOP_DWELL_CYC = CNT_W'(TOP_DWELL_US * 1000 / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] BURN_CYC = CNT_W'(BURN_US * 1000 / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;

  // fuse field layout
  localparam int FUSE_W = 17;
  localparam int CODE_W = 6;
  localparam int KEY_W = 3;
  localparam int SENS_LSB = 0;
  localparam int SENS_W = 6;
  localparam int ZERO_LSB = 6;
  localparam int ZERO_W = 6;
  localparam int AUX_LSB = 12;
  localparam int AUX_W = 5;
  localparam int GTC_W = 3;
  localparam int POLARITY_BIT = 15;
  localparam int LOCK_BIT = 16;
  localparam logic [CODE_W-1:0] SENS_MAX = 6'h3f;
  localparam logic [CODE_W-1:0] ZERO_MAX = 6'h3f;
  localparam logic [CODE_W-1:0] AUX_MAX = 6'h1f;

  // register keys
  localparam logic [KEY_W-1:0] KEY_SENS = 3'h1;
  localparam logic [KEY_W-1:0] KEY_ZERO = 3'h2;
  localparam logic [KEY_W-1:0] KEY_AUX = 3'h3;
  localparam logic [KEY_W-1:0] KEY_MAX = 3'h7;

  // register map
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_TRIM = 4'h8;
  localparam logic [ADDR_W-1:0] REG_FUSE = 4'hc;
  localparam int CTRL_PROG_EN_BIT = 0;
  localparam logic CTRL_PROG_EN_RESET = 1'h1;
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_KEY_LSB = 4;
  localparam int STATUS_CODE_LSB = 8;
  localparam int STATUS_LOCK_BIT = 16;

  typedef enum logic [2:0] {
    ST_INIT = 3'h1,
    ST_SELECT = 3'h2,
    ST_ADDRESS = 3'h4
  } pfs_state_type;

  typedef enum logic [2:0] {
    LV_LOW = 3'h1,
    LV_MID = 3'h2,
    LV_TOP = 3'h4
  } pfs_lvl_type;

  typedef struct packed {
    logic locked;
    logic output_polarity;
    logic [GTC_W-1:0] gain_temp_coefficient;
    logic [ZERO_W-1:0] zero_field_output;
    logic [SENS_W-1:0] sensitivity;
  } pfs_trim_type;

  function automatic logic [CODE_W-1:0] field_max(input logic [KEY_W-1:0] key);
    case (key)
      KEY_SENS: field_max = SENS_MAX;
      KEY_ZERO: field_max = ZERO_MAX;
      KEY_AUX: field_max = AUX_MAX;
      default: field_max = 6'h00;
    endcase
  endfunction : field_max

  // place a code of the keyed field onto the whole fuse vector
  function automatic logic [FUSE_W-1:0] code_mask(input logic [KEY_W-1:0] key,
                                                  input logic [CODE_W-1:0] code);
    logic [FUSE_W-1:0] m;
    m = '0;
    case (key)
      KEY_SENS: m[SENS_LSB +: SENS_W] = code[SENS_W-1:0];
      KEY_ZERO: m[ZERO_LSB +: ZERO_W] = code[ZERO_W-1:0];
      KEY_AUX: m[AUX_LSB +: AUX_W] = code[AUX_W-1:0];
      default: m = '0;
    endcase
    return m;
  endfunction : code_mask

endpackage : pfs_pkg

//--- logic/pfs_pulse_classifier.sv
// module: synchronises the pin comparators and classifies programming pulses
`timescale 1ns/10ps
module pfs_pulse_classifier import pfs_pkg::*; (
  // clock and reset
  input logic clk,
  input logic rst_n,
  // pin comparators, asynchronous
  input logic mid_cmp_raw,
  input logic top_cmp_raw,
  // classified events
  output logic mid_evt,
  output logic high_evt,
  output logic burn_evt
);

  logic mid_s1_q, mid_s2_q, top_s1_q, top_s2_q;
  pfs_lvl_type lvl_q, lvl_d, lvl_in;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic mid_ok_q, mid_ok_d, top_ok_q, top_ok_d;
  logic mid_evt_q, mid_evt_d, high_evt_q, high_evt_d, burn_evt_q, burn_evt_d;
  logic ending;

  always_comb begin
    lvl_in = top_s2_q ? LV_TOP : (mid_s2_q ? LV_MID : LV_LOW);
    lvl_d = lvl_in;
    cnt_d = (lvl_in != lvl_q) ? '0 : ((cnt_q == CNT_MAX) ? cnt_q : cnt_q + 12'h001);
    ending = (lvl_in == LV_LOW) && (lvl_q != LV_LOW);
    // excursions shorter than the dwell never qualify
    mid_ok_d = mid_ok_q | (lvl_q == LV_MID && lvl_in == LV_MID
                           && cnt_q >= MID_DWELL_CYC - 12'h001);
    top_ok_d = top_ok_q | (lvl_q == LV_TOP && lvl_in == LV_TOP
                           && cnt_q >= TOP_DWELL_CYC - 12'h001);
    if (lvl_in == LV_LOW) begin
      mid_ok_d = 1'b0;
      top_ok_d = 1'b0;
    end
    // the highest qualified level reached decides the kind
    mid_evt_d = ending && mid_ok_q && !top_ok_q;
    high_evt_d = ending && top_ok_q;
    burn_evt_d = lvl_q == LV_TOP && lvl_in == LV_TOP && cnt_q == BURN_CYC - 12'h001;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mid_s1_q <= 1'b0;
      mid_s2_q <= 1'b0;
      top_s1_q <= 1'b0;
      top_s2_q <= 1'b0;
      lvl_q <= LV_LOW;
      cnt_q <= '0;
      mid_ok_q <= 1'b0;
      top_ok_q <= 1'b0;
      mid_evt_q <= 1'b0;
      high_evt_q <= 1'b0;
      burn_evt_q <= 1'b0;
    end else begin
      mid_s1_q <= mid_cmp_raw;
      mid_s2_q <= mid_s1_q;
      top_s1_q <= top_cmp_raw;
      top_s2_q <= top_s1_q;
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
      mid_ok_q <= mid_ok_d;
      top_ok_q <= top_ok_d;
      mid_evt_q <= mid_evt_d;
      high_evt_q <= high_evt_d;
      burn_evt_q <= burn_evt_d;
    end
  end

  assign mid_evt = mid_evt_q;
  assign high_evt = high_evt_q;
  assign burn_evt = burn_evt_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_top_dwell;
    $rose(top_ok_q) |-> $past(cnt_q) == TOP_DWELL_CYC - 12'h001 && $past(lvl_q) == LV_TOP;
  endproperty
  a_top_dwell: assert property (p_top_dwell) else $error("top level qualified early");

  property p_kind_exclusive;
    mid_evt_q |-> !high_evt_q && !$past(top_ok_q, 2) && $past(mid_ok_q, 2);
  endproperty
  a_kind_exclusive: assert property (p_kind_exclusive) else $error("mid pulse misclassified");

endmodule : pfs_pulse_classifier

//--- logic/pfs_fuse_bank.sv
// module: one-time fuse array, bits only ever go from intact to blown
`timescale 1ns/10ps
module pfs_fuse_bank import pfs_pkg::*; (
  // clock, reset and virgin-part model
  input logic clk,
  input logic rst_n,
  input logic virgin_n,
  // blow request
  input logic blow_en,
  input logic [FUSE_W-1:0] blow_mask,
  // fuse state
  output logic [FUSE_W-1:0] fuse_q
);

  logic [FUSE_W-1:0] fuse_d;

  // supply reset does not touch the fuses, only a virgin part starts clear
  always_comb begin
    fuse_d = fuse_q | (blow_en ? blow_mask : '0);
    if (!virgin_n) begin
      fuse_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    fuse_q <= fuse_d;
  end

  property p_fuse_hold;
    @(posedge clk) disable iff (!rst_n || !virgin_n)
    ##1 ($past(fuse_q) & ~fuse_q) == '0;
  endproperty
  a_fuse_hold: assert property (p_fuse_hold) else $error("blown fuse cleared");

endmodule : pfs_fuse_bank

//--- logic/pfs_fuse_trim.sv
// module: pin programmed fuse trim logic with an Avalon-MM status port
// Summary of operation
// - Two pulse kinds: high and mid, distinguished.
// - Try value temporary, cleared by supply cycle.
// - Only one parameter trialled at a time.
// - Blow makes permanent; parameters blown sequentially.
// - Lock fuse rejects all further programming.
// - Key equals mid pulse count; one is first.
// - Code is binary fuse value; one is bit0.
// - Addressed value applied while stepping, burnt later.
// - Blown fuse stays set forever.
// - Initial state ignores mid; high enters selection.
// - High pulse in selection enters addressing; code does so only for keys 1 to 3, other keys go back to init.
// - Mid falling edge increments code, saturating.
// - Keys: 1 sensitivity, 2 zero output, 3 auxiliary.
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module pfs_fuse_trim import pfs_pkg::*; (
  // clock and supply reset
  input logic clk,
  input logic rst_n,
  // virgin part model, low clears the fuse array
  input logic virgin_n,
  // sensor_output_pin comparators, asynchronous
  input logic mid_cmp_raw,
  input logic top_cmp_raw,
  // applied trim and fuse burn driver
  output pfs_trim_type trim,
  output logic burn_strobe,
  output logic [FUSE_W-1:0] burn_mask,
  // Avalon-MM slave
  input logic [ADDR_W-1:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  logic mid_evt, high_evt, burn_evt;
  logic [FUSE_W-1:0] fuse_q;
  logic locked;

  pfs_pulse_classifier u_classifier (
    .clk(clk),
    .rst_n(rst_n),
    .mid_cmp_raw(mid_cmp_raw),
    .top_cmp_raw(top_cmp_raw),
    .mid_evt(mid_evt),
    .high_evt(high_evt),
    .burn_evt(burn_evt)
  );

  // programming state
  pfs_state_type state_q, state_d;
  logic [KEY_W-1:0] key_q, key_d;
  logic [CODE_W-1:0] code_q, code_d;
  logic prog_en_q, prog_en_d;
  logic mid_go, high_go, burn_go;
  logic [FUSE_W-1:0] try_mask;

  assign locked = fuse_q[LOCK_BIT];
  // programming is off while software holds it off or once the part is locked
  assign mid_go = mid_evt && prog_en_q && !locked;
  assign high_go = high_evt && prog_en_q && !locked;
  assign burn_go = burn_evt && prog_en_q && !locked && state_q == ST_ADDRESS;

  always_comb begin
    state_d = state_q;
    key_d = key_q;
    code_d = code_q;
    case (state_q)
      ST_INIT: begin
        // mid pulses are dropped here on purpose
        if (high_go) begin
          state_d = ST_SELECT;
          key_d = '0;
        end
      end
      ST_SELECT: begin
        if (mid_go && key_q != KEY_MAX) begin
          key_d = key_q + 3'h1;
        end
        if (high_go) begin
          code_d = '0;
          // an unknown key falls back rather than address nothing
          if (key_q == KEY_SENS || key_q == KEY_ZERO || key_q == KEY_AUX) begin
            state_d = ST_ADDRESS;
          end else begin
            state_d = ST_INIT;
          end
        end
      end
      ST_ADDRESS: begin
        // stays on one key until the supply is cycled, so one trial at a time
        if (mid_go && code_q != field_max(key_q)) begin
          code_d = code_q + 6'h01;
        end
      end
      default: begin
        state_d = ST_INIT;
        key_d = '0;
        code_d = '0;
      end
    endcase
    if (locked) begin
      state_d = ST_INIT;
    end
  end

  // the code is a plain binary value laid onto the keyed field
  assign try_mask = (state_q == ST_ADDRESS) ? code_mask(key_q, code_q) : '0;

  // fuse array, burnt from the addressed code while the top level is held
  pfs_fuse_bank u_fuses (
    .clk(clk),
    .rst_n(rst_n),
    .virgin_n(virgin_n),
    .blow_en(burn_go),
    .blow_mask(try_mask),
    .fuse_q(fuse_q)
  );

  // applied trim: blown bits plus the code being tried
  pfs_trim_type trim_q, trim_d;
  logic burn_strobe_q, burn_strobe_d;
  logic [FUSE_W-1:0] burn_mask_q, burn_mask_d;
  logic [FUSE_W-1:0] eff;

  always_comb begin
    eff = fuse_q | try_mask;
    trim_d.sensitivity = eff[SENS_LSB +: SENS_W];
    trim_d.zero_field_output = eff[ZERO_LSB +: ZERO_W];
    trim_d.gain_temp_coefficient = eff[AUX_LSB +: GTC_W];
    trim_d.output_polarity = eff[POLARITY_BIT];
    // a tried lock bit must not lock; only the blown fuse does
    trim_d.locked = fuse_q[LOCK_BIT];
    burn_strobe_d = burn_go;
    burn_mask_d = burn_go ? try_mask : '0;
  end

  // register port: one wait state, then the answer
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[STATUS_STATE_LSB +: 3] = state_q;
    status_word[STATUS_KEY_LSB +: KEY_W] = key_q;
    status_word[STATUS_CODE_LSB +: CODE_W] = code_q;
    status_word[STATUS_LOCK_BIT] = locked;
  end

  always_comb begin
    ack_d = (avs_read || avs_write) && !ack_q;
    rdata_d = rdata_q;
    prog_en_d = prog_en_q;
    if (ack_d && avs_read) begin
      case (avs_address)
        REG_CTRL: rdata_d = {31'h0, prog_en_q};
        REG_STATUS: rdata_d = status_word;
        REG_TRIM: rdata_d = {15'h0, trim_q};
        REG_FUSE: rdata_d = {15'h0, fuse_q};
        default: rdata_d = 32'h0;
      endcase
    end
    if (ack_q && avs_write && avs_address == REG_CTRL) begin
      prog_en_d = avs_writedata[CTRL_PROG_EN_BIT];
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // supply reset clears every tried value
      state_q <= ST_INIT;
      key_q <= '0;
      code_q <= '0;
      prog_en_q <= CTRL_PROG_EN_RESET;
      trim_q <= '0;
      burn_strobe_q <= 1'b0;
      burn_mask_q <= '0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      state_q <= state_d;
      key_q <= key_d;
      code_q <= code_d;
      prog_en_q <= prog_en_d;
      trim_q <= trim_d;
      burn_strobe_q <= burn_strobe_d;
      burn_mask_q <= burn_mask_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign trim = trim_q;
  assign burn_strobe = burn_strobe_q;
  assign burn_mask = burn_mask_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_init_ignores_mid;
    state_q == ST_INIT && mid_evt && !high_evt |=> state_q == ST_INIT;
  endproperty
  a_init_ignores_mid: assert property (p_init_ignores_mid) else $error("mid left init");

  property p_init_to_select;
    state_q == ST_INIT && high_evt && prog_en_q && !locked |=> state_q == ST_SELECT && key_q == 3'h0;
  endproperty
  a_init_to_select: assert property (p_init_to_select) else $error("high missed in init");

  sequence s_key_chosen;
    state_q == ST_SELECT && !locked && prog_en_q && key_q >= 3'h1 && key_q <= 3'h3;
  endsequence

  property p_select_to_address;
    s_key_chosen ##0 high_evt |=> state_q == ST_ADDRESS && code_q == 6'h00 ##1 try_mask == '0;
  endproperty
  a_select_to_address: assert property (p_select_to_address) else $error("no addressing");

  property p_key_count;
    state_q == ST_SELECT && mid_go && key_q < 3'h7 |=> key_q == $past(key_q) + 3'h1;
  endproperty
  a_key_count: assert property (p_key_count) else $error("key not counted");

  // blown bits may already cover the new code, so only demand that the code shows up
  property p_code_step;
    state_q == ST_ADDRESS && mid_go && code_q < field_max(key_q)
      |=> code_q == $past(code_q) + 6'h01
      ##1 (trim_q[15:0] & $past(try_mask[15:0])) == $past(try_mask[15:0]) || locked;
  endproperty
  a_code_step: assert property (p_code_step) else $error("code not stepped");

  property p_code_saturates;
    state_q == ST_ADDRESS && code_q == field_max(key_q) |=> code_q == $past(code_q) || locked;
  endproperty
  a_code_saturates: assert property (p_code_saturates) else $error("code passed maximum");

  property p_sens_applied;
    state_q == ST_ADDRESS && key_q == KEY_SENS && code_q == 6'h01
      |=> trim_q.sensitivity[0] && trim_q.zero_field_output == $past(fuse_q[ZERO_LSB +: ZERO_W]);
  endproperty
  a_sens_applied: assert property (p_sens_applied) else $error("code one not on bit0");

  property p_locked_rejects;
    locked |-> !burn_go ##1 state_q == ST_INIT && !burn_strobe_q;
  endproperty
  a_locked_rejects: assert property (p_locked_rejects) else $error("locked part programmed");

  sequence s_burn_landed;
    burn_strobe_q && (fuse_q & burn_mask_q) == burn_mask_q;
  endsequence

  property p_burn_follows;
    burn_go |=> s_burn_landed;
  endproperty
  a_burn_follows: assert property (p_burn_follows) else $error("burn not applied");

  property p_burn_in_address;
    burn_strobe_q |-> $past(state_q) == ST_ADDRESS && burn_mask_q == $past(try_mask);
  endproperty
  a_burn_in_address: assert property (p_burn_in_address) else $error("burn off address");

  // outside addressing nothing tried may reach the trim outputs
  property p_try_outside;
    state_q != ST_ADDRESS |-> try_mask == '0;
  endproperty
  a_try_outside: assert property (p_try_outside) else $error("stale tried value");

  property p_one_field;
    state_q == ST_ADDRESS |-> (try_mask & ~code_mask(key_q, 6'h3f)) == '0;
  endproperty
  a_one_field: assert property (p_one_field) else $error("trial outside keyed field");

  // the key is frozen once addressing starts, a second trial needs a supply cycle
  property p_key_held;
    state_q == ST_ADDRESS && !locked |=> state_q == ST_ADDRESS && key_q == $past(key_q);
  endproperty
  a_key_held: assert property (p_key_held) else $error("key changed while addressing");

  property p_code_bounded;
    state_q == ST_ADDRESS |-> code_q <= field_max(key_q);
  endproperty
  a_code_bounded: assert property (p_code_bounded) else $error("code above field maximum");

  property p_trim_locked;
    locked |=> trim_q.locked;
  endproperty
  a_trim_locked: assert property (p_trim_locked) else $error("lock not shown on trim");

  // exactly one wait state, whatever the master does next
  property p_bus_one_wait;
    (avs_read || avs_write) && !ack_q |=> !avs_waitrequest;
  endproperty
  a_bus_one_wait: assert property (p_bus_one_wait) else $error("bus answer late");

endmodule : pfs_fuse_trim

//--- verification/pfs_programmer.sv
// partner model: end-of-line programmer driving the pin comparators
`timescale 1ns/10ps
module pfs_programmer (
  // clock
  input logic clk,
  // pin comparators
  output logic mid_cmp_raw,
  output logic top_cmp_raw
);
  initial begin
    mid_cmp_raw = 1'b0;
    top_cmp_raw = 1'b0;
  end

  // the pin passes middle_level on its way to top_level, so mid rises with top
  task automatic pulse(input logic top, input int dwell);
    @(posedge clk);
    mid_cmp_raw <= 1'b1;
    top_cmp_raw <= top;
    repeat (dwell) @(posedge clk);
    mid_cmp_raw <= 1'b0;
    top_cmp_raw <= 1'b0;
    repeat (top ? 3010 : 510) @(posedge clk);
  endtask : pulse
endmodule : pfs_programmer

//--- verification/tb_pfs_fuse_trim.sv
// testbench: pulse programming, fuse burning and register port of the trim block
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_pfs_fuse_trim import pfs_pkg::*;;
  localparam int MID_T = 1505;
  localparam int TOP_T = 3010;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] exp;
  } pfs_row_type;
  logic clk;
  logic rst_n;
  logic virgin_n;
  logic mid_cmp_raw;
  logic top_cmp_raw;
  pfs_trim_type trim;
  logic burn_strobe;
  logic [FUSE_W-1:0] burn_mask;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] rd;
  logic [FUSE_W-1:0] last_mask;
  int error_cnt;
  int n_checks;
  int burns;
  // reset values, plus one unmapped address that must read zero
  pfs_row_type rows [5] = '{'{REG_CTRL, 32'h00000001}, '{REG_STATUS, 32'h00000001},
    '{REG_TRIM, 32'h00000000}, '{REG_FUSE, 32'h00000000}, '{4'h2, 32'h00000000}};

  pfs_fuse_trim dut (
    .clk(clk), .rst_n(rst_n), .virgin_n(virgin_n),
    .mid_cmp_raw(mid_cmp_raw), .top_cmp_raw(top_cmp_raw),
    .trim(trim), .burn_strobe(burn_strobe), .burn_mask(burn_mask),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  pfs_programmer prog (
    .clk(clk), .mid_cmp_raw(mid_cmp_raw), .top_cmp_raw(top_cmp_raw)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // counting strobe cycles also proves the strobe lasts a single cycle
  always @(negedge clk) begin
    if (burn_strobe === 1'b1) begin
      burns++;
      last_mask = burn_mask;
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      complete_run();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic st();
    bus(1'b0, REG_STATUS, 32'h00000000);
  endtask : st

  task automatic supply_cycle();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : supply_cycle

  initial begin
    repeat (97000) @(posedge clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    virgin_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    error_cnt = 0;
    n_checks = 0;
    burns = 0;
    last_mask = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    virgin_n <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b0, rows[i].addr, 32'h00000000);
      `CHK(rd, rows[i].exp)
    end
    bus(1'b1, REG_CTRL, 32'h00000000);
    bus(1'b0, REG_CTRL, 32'h00000000);
    `CHK(rd[0], 1'b0)
    bus(1'b1, REG_CTRL, 32'h00000001);
    // status is read-only, a write must leave it alone
    bus(1'b1, REG_STATUS, 32'h0000ffff);
    st();
    `CHK(rd[2:0], 3'h1)
    // first try and burn of one sensitivity bit
    prog.pulse(1'b0, MID_T);
    st();
    `CHK(rd[2:0], 3'h1)
    prog.pulse(1'b1, TOP_T);
    st();
    `CHK(rd[6:0], 7'h02)
    prog.pulse(1'b0, MID_T);
    st();
    `CHK(rd[6:0], 7'h12)
    prog.pulse(1'b1, TOP_T);
    st();
    `CHK(rd[6:0], 7'h14)
    prog.pulse(1'b0, MID_T);
    st();
    `CHK(rd[13:8], 6'h01)
    `CHK(trim.sensitivity, 6'h01)
    prog.pulse(1'b0, 1000);
    st();
    `CHK(rd[13:8], 6'h01)
    prog.pulse(1'b1, TOP_T);
    `CHK(burns, 1)
    `CHK(last_mask, 17'h00001)
    bus(1'b0, REG_FUSE, 32'h00000000);
    `CHK(rd, 32'h00000001)
    // the part stays addressed after a burn until the supply is cycled
    st();
    `CHK(rd[2:0], 3'h4)
    // a second bit tried on top of the blown one, then dropped by a supply cycle
    prog.pulse(1'b0, MID_T);
    `CHK(trim.sensitivity, 6'h03)
    `CHK(trim.zero_field_output, 6'h00)
    supply_cycle();
    `CHK(trim.sensitivity, 6'h01)
    // lock bit is code 16 of the third register
    prog.pulse(1'b1, TOP_T);
    repeat (3) prog.pulse(1'b0, MID_T);
    prog.pulse(1'b1, TOP_T);
    st();
    `CHK(rd[6:0], 7'h34)
    repeat (16) prog.pulse(1'b0, MID_T);
    st();
    `CHK(rd[13:8], 6'h10)
    prog.pulse(1'b1, TOP_T);
    `CHK(last_mask, 17'h10000)
    `CHK(trim.locked, 1'b1)
    st();
    `CHK(rd[16], 1'b1)
    prog.pulse(1'b1, TOP_T);
    st();
    `CHK(rd[2:0], 3'h1)
    `CHK(burns, 2)
    bus(1'b0, REG_FUSE, 32'h00000000);
    `CHK(rd, 32'h00010001)
    complete_run();
  end
endmodule : tb_pfs_fuse_trim
